/* File: flash_ctl_pkg.sv */
// Purpose: shared constants and types for the flash erase/write control block
// Assumes: 8-bit special-function register bus, 16-bit program address space
// Notes:   offsets are the processor's SFR addresses
package flash_ctl_pkg;
	localparam logic [7:0]  ERASE_INIT_ADDR = 8'h94;
	localparam logic [7:0]  FLASH_CTL_ADDR  = 8'hb2;
	localparam logic [7:0]  PAGE_ADDR_ADDR  = 8'hb7;
	localparam int          PROG_EN_BIT     = 0;
	localparam int          MASS_EN_BIT     = 1;
	localparam int          POST_EN_BIT     = 2;
	localparam int          PEND_BIT        = 3;
	localparam int          PAGE_LSB        = 1;
	localparam logic [7:0]  PAGE_ERASE_PAT  = 8'h55;
	localparam logic [7:0]  MASS_ERASE_PAT  = 8'haa;
	localparam logic [3:0]  UNLOCK_VALUE    = 4'h2;
	localparam logic [6:0]  PAGE_MAX        = 7'h3f;
	localparam logic [6:0]  PAGE_RESET      = 7'h00;
	localparam logic [7:0]  BYTE_RESET      = 8'h00;
	localparam int          FLASH_ADDR_W    = 16;

	// register bus request
	typedef struct packed {
		logic        we;
		logic        re;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} sfr_req_s;

	// external-data store from the processor
	typedef struct packed {
		logic                    we;
		logic [FLASH_ADDR_W-1:0] addr;
		logic [7:0]              data;
	} xstore_s;

	// command to the flash array
	typedef struct packed {
		logic                    wr;
		logic                    page_erase;
		logic                    mass_erase;
		logic [FLASH_ADDR_W-1:0] addr;
		logic [7:0]              data;
	} flash_cmd_s;

	typedef struct packed {
		logic                    dbg_meta;
		logic                    dbg_sync;
		logic                    busy_q;
		logic                    prog_en;
		logic                    mass_en;
		logic                    post_en;
		logic                    pend;
		logic                    page_armed;
		logic [6:0]              page;
		logic [FLASH_ADDR_W-1:0] q_addr;
		logic [7:0]              q_data;
		logic [7:0]              rdata;
		flash_cmd_s              cmd;
	} st_s;
endpackage

/* File: flash_erase_write_control.sv */
// Purpose: erase and program sequencing for the on-chip flash
// Assumes: CE_BUSY, CE_ENABLE, UNLOCK_KEY, IRQ_EN come from logic on REF_CLK
// Notes:   DEBUG_PORT_EN is a pin and is synchronised before use
// Notes on behaviour
// - pattern 0x55 to erase-initiate erases the page previously written.
// - pattern 0xaa erases all, needs mass-erase enable and debug port.
// - any other erase-initiate value is dropped with no effect.
// - mass-erase enable is write-only, resets off, good for one erase.
// - page address is write-only, pages 0 to 63, rewritten per erase.
// - posted mode with engine on queues one write until busy falls.
// - readable pending flag shows a queued write not yet done.
// - while pending, further flash write requests are ignored.
// - program-write enable routes stores to flash, self clears, locked by interrupts.
// - no erase or program unless the unlock key equals two.
`timescale 1ns/1ps
module flash_erase_write_control (
	// clock and reset
	input  wire logic                                    REF_CLK,
	input  wire logic                                    RST_N,
	// special-function register bus
	input  wire flash_ctl_pkg::sfr_req_s                 SFR_REQ,
	output logic [7:0]                                   SFR_RDATA,
	// processor store and status
	input  wire flash_ctl_pkg::xstore_s                  XSTORE,
	input  wire logic                                    IRQ_EN,
	input  wire logic [3:0]                              UNLOCK_KEY,
	input  wire logic                                    DEBUG_PORT_EN,
	// compute engine
	input  wire logic                                    CE_ENABLE,
	input  wire logic                                    CE_BUSY,
	// flash array
	output flash_ctl_pkg::flash_cmd_s                    FLASH_CMD,
	output logic [6:0]                                   FLASH_PAGE
);
	import flash_ctl_pkg::*;

	// elaboration check: the store path carries at least one byte of address
	if (FLASH_ADDR_W < 8) begin : g_addr_check
		$error("flash address too narrow");
	end

	st_s st_q;
	st_s st_d;

	function automatic logic wr_hit(input sfr_req_s r, input logic [7:0] a);
		wr_hit = r.we && (r.addr == a);
	endfunction

	function automatic logic [7:0] read_mux(input st_s s, input logic [7:0] a);
		logic [7:0] v;
		v = BYTE_RESET;
		// write-only fields read as zero
		if (a == FLASH_CTL_ADDR) begin
			v[PROG_EN_BIT] = s.prog_en;
			v[POST_EN_BIT] = s.post_en;
			v[PEND_BIT]    = s.pend;
		end
		read_mux = v;
	endfunction

	logic unlock_ok;
	logic wr_req;
	logic busy_fall;
	logic posted_mode;

	assign unlock_ok   = (UNLOCK_KEY == UNLOCK_VALUE);
	assign wr_req      = XSTORE.we && st_q.prog_en;
	assign busy_fall   = st_q.busy_q && !CE_BUSY;
	assign posted_mode = st_q.post_en && CE_ENABLE;

	always_comb begin
		st_d          = st_q;
		// debug pin is asynchronous: only the second stage is read
		st_d.dbg_meta = DEBUG_PORT_EN;
		st_d.dbg_sync = st_q.dbg_meta;
		st_d.busy_q   = CE_BUSY;
		st_d.cmd.wr         = 1'b0;
		st_d.cmd.page_erase = 1'b0;
		st_d.cmd.mass_erase = 1'b0;
		if (SFR_REQ.re) begin
			st_d.rdata = read_mux(st_q, SFR_REQ.addr);
		end
		if (wr_hit(SFR_REQ, FLASH_CTL_ADDR)) begin
			st_d.post_en = SFR_REQ.wdata[POST_EN_BIT];
			st_d.mass_en = SFR_REQ.wdata[MASS_EN_BIT];
			// enable write lock
			// only the program enable is blocked; the other bits still land
			if (!IRQ_EN) begin
				st_d.prog_en = SFR_REQ.wdata[PROG_EN_BIT];
			end
		end
		if (wr_hit(SFR_REQ, PAGE_ADDR_ADDR)) begin
			st_d.page       = SFR_REQ.wdata[7:PAGE_LSB];
			st_d.page_armed = 1'b1;
		end
		if (wr_hit(SFR_REQ, ERASE_INIT_ADDR)) begin
			if (SFR_REQ.wdata == PAGE_ERASE_PAT) begin
				st_d.page_armed = 1'b0;
				if (st_q.page_armed && st_q.page <= PAGE_MAX && unlock_ok && !st_q.pend) begin
					st_d.cmd.page_erase = 1'b1;
				end
			end else if (SFR_REQ.wdata == MASS_ERASE_PAT) begin
				st_d.mass_en = 1'b0;
				if (st_q.mass_en && st_q.dbg_sync && unlock_ok && !st_q.pend) begin
					st_d.cmd.mass_erase = 1'b1;
				end
			end
		end
		if (st_q.pend && busy_fall) begin
			st_d.pend = 1'b0;
			// key re-checked here: a relock drops the queued byte
			if (unlock_ok) begin
				st_d.cmd.wr   = 1'b1;
				st_d.cmd.addr = st_q.q_addr;
				st_d.cmd.data = st_q.q_data;
			end
		end
		if (wr_req) begin
			st_d.prog_en = 1'b0;
			// ignore while pending
			// a store in the drain cycle is dropped too; the slot frees next cycle
			if (!st_q.pend && unlock_ok) begin
				if (posted_mode) begin
					st_d.pend   = 1'b1;
					st_d.q_addr = XSTORE.addr;
					st_d.q_data = XSTORE.data;
				end else begin
					st_d.cmd.wr   = 1'b1;
					st_d.cmd.addr = XSTORE.addr;
					st_d.cmd.data = XSTORE.data;
				end
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign SFR_RDATA  = st_q.rdata;
	assign FLASH_CMD  = st_q.cmd;
	assign FLASH_PAGE = st_q.page;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_page_go;
		wr_hit(SFR_REQ, ERASE_INIT_ADDR) && SFR_REQ.wdata == PAGE_ERASE_PAT
			&& st_q.page_armed && st_q.page <= PAGE_MAX && unlock_ok && !st_q.pend;
	endsequence
	sequence s_post_req;
		wr_req && posted_mode && !st_q.pend && unlock_ok;
	endsequence
	sequence s_drain;
		st_q.pend && busy_fall && unlock_ok;
	endsequence

	// request shapes for the checks below
	sequence s_mass_try;
		wr_hit(SFR_REQ, ERASE_INIT_ADDR) && SFR_REQ.wdata == MASS_ERASE_PAT;
	endsequence
	sequence s_imm_req;
		wr_req && !posted_mode && !st_q.pend && unlock_ok;
	endsequence
	sequence s_locked_req;
		wr_req && !unlock_ok && !st_q.pend;
	endsequence

	a_page_erase_go: assert property (s_page_go |=> FLASH_CMD.page_erase && !st_q.page_armed)
		else $error("page erase not started");
	a_mass_erase_gate: assert property (
		FLASH_CMD.mass_erase |-> $past(st_q.mass_en) && $past(st_q.dbg_sync) && !st_q.mass_en)
		else $error("mass erase without enables");
	a_mass_once: assert property (s_mass_try |=> !st_q.mass_en)
		else $error("mass erase enable not consumed");
	a_other_pattern: assert property (
		wr_hit(SFR_REQ, ERASE_INIT_ADDR)
		&& SFR_REQ.wdata != PAGE_ERASE_PAT && SFR_REQ.wdata != MASS_ERASE_PAT
		|=> !FLASH_CMD.page_erase && !FLASH_CMD.mass_erase)
		else $error("erase from unknown pattern");
	a_page_rearm: assert property (
		FLASH_CMD.page_erase |-> $past(st_q.page_armed) && $past(st_q.page) <= PAGE_MAX)
		else $error("page erase without fresh address");
	a_post_hold: assert property (s_post_req |=> st_q.pend && !FLASH_CMD.wr)
		else $error("posted write not queued");
	a_imm_write: assert property (
		s_imm_req |=> FLASH_CMD.wr && FLASH_CMD.addr == $past(XSTORE.addr)
		&& FLASH_CMD.data == $past(XSTORE.data))
		else $error("immediate write not issued");
	a_drain_write: assert property (
		s_drain |=> FLASH_CMD.wr && !st_q.pend && FLASH_CMD.addr == $past(st_q.q_addr)
		&& FLASH_CMD.data == $past(st_q.q_data))
		else $error("queued write not drained");
	a_pend_read: assert property (
		SFR_REQ.re && SFR_REQ.addr == FLASH_CTL_ADDR
		|=> SFR_RDATA[PEND_BIT] == $past(st_q.pend))
		else $error("pending flag misread");
	a_pend_ignore: assert property (
		st_q.pend && wr_req && !busy_fall
		|=> st_q.pend && !FLASH_CMD.wr && $stable(st_q.q_addr) && $stable(st_q.q_data))
		else $error("write accepted while pending");
	a_prog_clear: assert property (wr_req |=> !st_q.prog_en)
		else $error("program enable not cleared");
	a_prog_lock: assert property (
		IRQ_EN && !wr_req |=> st_q.prog_en == $past(st_q.prog_en))
		else $error("program enable changed under interrupts");
	a_locked_store: assert property (s_locked_req |=> !FLASH_CMD.wr && !st_q.pend)
		else $error("store taken while locked");
	a_unlock_gate: assert property (
		FLASH_CMD.wr || FLASH_CMD.page_erase || FLASH_CMD.mass_erase
		|-> $past(UNLOCK_KEY) == UNLOCK_VALUE)
		else $error("flash modified while locked");
endmodule

/* File: flash_model.sv */
// Purpose: flash array and compute engine stand-in
// Assumes: commands arrive as one-cycle pulses
// Notes:   busy follows the bench hold request one edge late
`timescale 1ns/1ps
module flash_model (
	// clock
	input  wire logic                      clk,
	// flash commands
	input  wire flash_ctl_pkg::flash_cmd_s cmd,
	input  wire logic [6:0]                page,
	// engine
	input  wire logic                      hold,
	output logic                           busy
);
	import flash_ctl_pkg::*;
	int          n_wr    = 0;
	int          n_pe    = 0;
	int          n_me    = 0;
	logic [23:0] last_wr = '0;
	logic [6:0]  last_pg = '0;
	// counts and last write and page only; contents not kept, the block never reads flash
	always @(posedge clk) begin
		busy <= hold;
		if (cmd.wr) begin
			n_wr <= n_wr + 1;
			last_wr <= {cmd.addr, cmd.data};
		end
		if (cmd.page_erase) begin
			n_pe <= n_pe + 1;
			last_pg <= page;
		end
		if (cmd.mass_erase) begin
			n_me <= n_me + 1;
		end
	end
endmodule

/* File: flash_erase_write_control_test.sv */
// Purpose: self-checking bench for flash erase/write control
// Assumes: flash_model stands in for array and engine
// Notes:   expected counts kept here, compared after each erase and store sequence
`timescale 1ns/1ps
module flash_erase_write_control_test;
	import flash_ctl_pkg::*;
	logic       clk   = 1'b0;
	logic       rst_n = 1'b0;
	sfr_req_s   req   = '0;
	xstore_s    xs    = '0;
	logic       irq   = 1'b0;
	logic [3:0] key   = UNLOCK_VALUE;
	logic       dbg   = 1'b1;
	logic       ce_en = 1'b0;
	logic       hold  = 1'b0;
	logic [7:0] rdata;
	flash_cmd_s cmd;
	logic [6:0] page;
	logic       busy;
	int         fails       = 0;
	int         check_count = 0;
	int         e_wr        = 0;
	int         e_pe        = 0;
	int         e_me        = 0;
	flash_erase_write_control DUT (.REF_CLK(clk), .RST_N(rst_n), .SFR_REQ(req),
		.SFR_RDATA(rdata), .XSTORE(xs), .IRQ_EN(irq), .UNLOCK_KEY(key),
		.DEBUG_PORT_EN(dbg), .CE_ENABLE(ce_en), .CE_BUSY(busy),
		.FLASH_CMD(cmd), .FLASH_PAGE(page));
	flash_model P (.clk(clk), .cmd(cmd), .page(page), .hold(hold), .busy(busy));
	initial forever #10 clk = ~clk;
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		chk(24'(rdata), 24'(e));
	endtask
	task automatic st(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		xs <= '{1'b1, a, d};
		@(posedge clk);
		xs <= '0;
	endtask
	task automatic cnt();
		repeat (5) @(posedge clk);
		chk(24'(P.n_wr), 24'(e_wr));
		chk(24'(P.n_pe), 24'(e_pe));
		chk(24'(P.n_me), 24'(e_me));
	endtask
	task automatic s_regs();
		rd(8'hb2, 8'h00);
		rd(8'h94, 8'h00);
		rd(8'hb7, 8'h00);
		rd(8'h10, 8'h00);
		wr(8'hb2, 8'h0c);
		rd(8'hb2, 8'h04);
		wr(8'hb2, 8'h00);
	endtask
	task automatic s_page();
		wr(8'hb7, 8'h0a);
		wr(8'h94, 8'h55);
		e_pe++;
		cnt();
		chk(24'(P.last_pg), 24'h5);
		wr(8'h94, 8'h55);
		cnt();
		wr(8'hb7, 8'h80);
		wr(8'h94, 8'h55);
		cnt();
		wr(8'hb7, 8'h7e);
		wr(8'h94, 8'h55);
		e_pe++;
		cnt();
		chk(24'(P.last_pg), 24'h3f);
	endtask
	task automatic s_mass();
		wr(8'h94, 8'haa);
		cnt();
		wr(8'hb2, 8'h02);
		wr(8'h94, 8'haa);
		e_me++;
		cnt();
		wr(8'h94, 8'haa);
		cnt();
		dbg <= 1'b0;
		wr(8'hb2, 8'h02);
		wr(8'h94, 8'haa);
		cnt();
		dbg <= 1'b1;
		wr(8'hb2, 8'h02);
		wr(8'hb7, 8'h0a);
		wr(8'h94, 8'h5a);
		cnt();
		wr(8'h94, 8'h55);
		wr(8'h94, 8'haa);
		e_pe++;
		e_me++;
		cnt();
	endtask
	task automatic s_key();
		key <= 4'h3;
		wr(8'hb7, 8'h0a);
		wr(8'h94, 8'h55);
		wr(8'hb2, 8'h01);
		st(16'h1234, 8'h56);
		cnt();
		key <= UNLOCK_VALUE;
	endtask
	task automatic s_imm();
		wr(8'hb2, 8'h05);
		st(16'h1234, 8'h56);
		e_wr++;
		cnt();
		chk(P.last_wr, 24'h123456);
		st(16'h1235, 8'h57);
		cnt();
		irq <= 1'b1;
		wr(8'hb2, 8'h01);
		irq <= 1'b0;
		st(16'h1236, 8'h58);
		cnt();
		rd(8'hb2, 8'h00);
	endtask
	task automatic s_post();
		ce_en <= 1'b1;
		hold <= 1'b1;
		wr(8'hb2, 8'h05);
		st(16'h0100, 8'ha5);
		rd(8'hb2, 8'h0c);
		wr(8'hb2, 8'h05);
		st(16'h0200, 8'h3c);
		cnt();
		hold <= 1'b0;
		e_wr++;
		cnt();
		chk(P.last_wr, 24'h0100a5);
		rd(8'hb2, 8'h04);
		ce_en <= 1'b0;
		wr(8'hb2, 8'h00);
	endtask
	initial begin
		#100us;
		fails++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		s_regs();
		s_page();
		s_mass();
		s_key();
		s_imm();
		s_post();
		results();
	end
endmodule
